/* design/cmd_link_unit.sv */
// acquisition-unit end of the framed serial command link
`timescale 1ns/100ps
// Operation
// [RULE_01] one command at a time; a new frame is taken only when idle
// [RULE_02] frame low starts a transfer; its release ends and completes it
// [RULE_03] every command holds two command bytes then two data bytes
// [RULE_04] long write: command bytes then any number of data bytes in one frame
// [RULE_05] unrecognised command answers with an error acknowledge
// [RULE_06] failure acknowledge echoes both received command bytes
// [RULE_07] read response echoes command bytes then the data bytes
// [RULE_08] good write acknowledged by a frame pulse only, no data or clock
// [RULE_09] any reply starts only after the incoming frame is released
// [RULE_10] correct read data is itself the read acknowledge
// [RULE_11] each direction has its own data, clock and frame
// [RULE_12] data and clock only driven or taken while frame is low
// [RULE_13] return frame is a hold only while the forward frame is low
// [RULE_14] source clock up to 10 MHz, any lower rate accepted
// [RULE_15] gaps between bytes inside a frame are allowed
// [RULE_16] clock phases need not be equal
// [RULE_17] sender withholds next byte while the return frame is low
// [RULE_18] hold is driven during the byte before the one held
// [RULE_19] long write may be held after its first two data bytes
// [RULE_20] any unit may pull the shared reset line low
// [RULE_21] a reset drive lasts at least 200 ms
// [RULE_22] the reset line is watched and resets the link logic fully
// [RULE_23] reset touches only link logic, no stored settings
// [RULE_24] watchdog forces a reset after about 30 s without progress
// [RULE_25] first command byte: three echo bits, three select bits, two zero bits
// [RULE_26] bytes go MSB first; sent on falling edge, taken on rising edge
module cmd_link_unit #(
	parameter int TX_HALF = link_pkg::TX_HALF_CYC,
	parameter int IORST_LEN = link_pkg::IORST_CYC,
	parameter logic [31:0] WDOG_LEN = link_pkg::WDOG_CYC,
	parameter logic [2:0] ITEM_LIMIT = link_pkg::ITEM_MAX
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link from the controller
	input wire logic rx_frame_n,
	input wire logic rx_clk,
	input wire logic rx_data,
	// link to the controller
	output logic tx_frame_n,
	output logic tx_clk,
	output logic tx_data,
	// shared reset line
	input wire logic io_rst_i,
	output logic io_rst_o,
	output logic io_rst_oe,
	input wire logic io_rst_req,
	// received bytes
	output logic rx_valid,
	input wire logic rx_ready,
	output link_pkg::rx_beat_s rx_beat,
	input wire logic long_path_ready,
	// command at frame end
	output logic cmd_valid,
	output link_pkg::cmd_info_s cmd,
	// response from the user
	input wire logic rsp_valid,
	output logic rsp_ready,
	input wire link_pkg::rsp_beat_s rsp,
	// status
	output logic link_reset
);
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RECV = 7'h02,
		ST_WAIT = 7'h04,
		ST_ACK = 7'h08,
		ST_NEXT = 7'h10,
		ST_SEND = 7'h20,
		ST_END = 7'h40
	} fsm_e;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] filt;
		fsm_e fsm;
		logic [7:0] rsh;
		logic [2:0] rbit;
		logic [15:0] rcnt;
		logic [7:0] cmd0;
		logic [7:0] cmd1;
		logic out_v;
		link_pkg::rx_beat_s out_b;
		logic skid_v;
		link_pkg::rx_beat_s skid_b;
		logic cmd_v;
		link_pkg::cmd_info_s cmd;
		logic want;
		logic rsp_rdy;
		logic beat_v;
		link_pkg::rsp_beat_s beat;
		logic fail;
		logic last_sent;
		logic [1:0] idx;
		logic [7:0] tsh;
		logic [2:0] tbit;
		logic phase;
		logic [15:0] div;
		logic tx_frame_n;
		logic tx_clk;
		logic tx_data;
		logic hold;
		logic [31:0] wd;
		logic io_oe;
		logic [31:0] io_cnt;
		logic link_rst;
	} state_s;

	function automatic state_s init_state();
		state_s s;
		s = '0;
		s.fsm = ST_IDLE;
		s.sync1 = 4'hF;
		s.sync2 = 4'hF;
		s.sync3 = 4'hF;
		s.filt = 4'hF;
		s.tx_frame_n = 1'b1;
		return s;
	endfunction : init_state

	function automatic logic cmd_known(input logic [7:0] c0);
		logic [2:0] sel;
		sel = c0[link_pkg::CMD0_SEL_HI:link_pkg::CMD0_SEL_LO];
		return (c0[link_pkg::CMD0_RSV_HI:link_pkg::CMD0_RSV_LO] == 2'h0) && (sel <= ITEM_LIMIT); // [RULE_25]
	endfunction : cmd_known

	localparam state_s INIT = init_state();
	localparam logic [15:0] HALF = 16'(TX_HALF);
	localparam logic [15:0] ACK_LEN = 16'(link_pkg::ACK_CYC);
	localparam logic [31:0] IO_LEN = 32'(IORST_LEN);

	state_s c;
	state_s n;
	logic f_frame_n;
	logic f_clk;
	logic f_data;
	logic f_io;
	logic rclk_rise;
	logic frame_fall;
	logic frame_rise;
	logic push;
	logic progress;
	link_pkg::rx_beat_s nb;

	assign f_frame_n = c.filt[0];
	assign f_clk = c.filt[1];
	assign f_data = c.filt[2];
	assign f_io = c.filt[3];

	always_comb begin
		n = c;
		nb = '0;
		push = 1'b0;
		progress = 1'b0;
		// pin synchroniser with agreement filter
		n.sync1 = {io_rst_i, rx_data, rx_clk, rx_frame_n};
		n.sync2 = c.sync1;
		n.sync3 = c.sync2;
		for (int i = 0; i < 4; i++) begin
			if (c.sync2[i] == c.sync3[i]) begin
				n.filt[i] = c.sync3[i];
			end
		end
		rclk_rise = n.filt[1] && !f_clk && !n.filt[0]; // [RULE_12] [RULE_14] [RULE_16] [RULE_26]
		frame_fall = !n.filt[0] && f_frame_n;
		frame_rise = n.filt[0] && !f_frame_n;
		n.cmd_v = 1'b0;
		// receive buffer drain
		if (c.out_v && rx_ready) begin
			n.out_v = c.skid_v;
			n.out_b = c.skid_b;
			n.skid_v = 1'b0;
		end
		// receive shifter
		if (c.fsm == ST_RECV && rclk_rise) begin
			n.rsh = {c.rsh[6:0], n.filt[2]}; // [RULE_26]
			n.rbit = c.rbit + 3'h1;
			if (c.rbit == 3'h7) begin
				push = 1'b1;
				progress = 1'b1;
				nb.data = {c.rsh[6:0], n.filt[2]};
				nb.first = (c.rcnt == 16'h0);
				if (c.rcnt == 16'h0) begin
					n.cmd0 = nb.data;
				end
				if (c.rcnt == 16'h1) begin
					n.cmd1 = nb.data;
				end
				if (c.rcnt != 16'hFFFF) begin
					n.rcnt = c.rcnt + 16'h1;
				end
			end
		end
		if (push) begin
			if (!n.out_v) begin
				n.out_v = 1'b1;
				n.out_b = nb;
			end else begin
				n.skid_v = 1'b1;
				n.skid_b = nb;
			end
		end
		// response beat handshake
		n.rsp_rdy = c.want && !c.beat_v && rsp_valid && !c.rsp_rdy;
		if (c.rsp_rdy && rsp_valid) begin
			n.beat_v = 1'b1;
			n.beat = rsp;
			n.want = !(rsp.last || rsp.fail);
		end
		// clock divider for the sending side
		if (c.div != 16'h0) begin
			n.div = c.div - 16'h1;
		end
		case (c.fsm)
			ST_IDLE: begin
				n.tx_frame_n = 1'b1;
				if (frame_fall) begin // [RULE_01] [RULE_02]
					n.fsm = ST_RECV;
					n.rcnt = 16'h0;
					n.rbit = 3'h0;
				end
			end
			ST_RECV: begin
				// hold while buffered bytes wait or the long write path is set up
				n.tx_frame_n = !(n.out_v || (c.cmd0[link_pkg::CMD0_LONG_BIT] && n.rcnt == 16'(link_pkg::HOLD_AT)
					&& !long_path_ready)); // [RULE_13] [RULE_18] [RULE_19]
				if (frame_rise) begin // [RULE_02] [RULE_09]
					n.tx_frame_n = 1'b1;
					n.cmd_v = 1'b1;
					n.cmd.cmd0 = c.cmd0;
					n.cmd.cmd1 = c.cmd1;
					n.cmd.is_read = c.cmd0[link_pkg::CMD0_DIR_BIT];
					n.cmd.is_long = c.cmd0[link_pkg::CMD0_LONG_BIT]; // [RULE_04]
					n.cmd.bytes = c.rcnt;
					n.cmd.bad = (c.rcnt < 16'(link_pkg::MIN_BYTES)) || !cmd_known(c.cmd0); // [RULE_03] [RULE_05]
					n.idx = 2'h0;
					n.last_sent = 1'b0;
					if (n.cmd.bad) begin
						n.fail = 1'b1; // [RULE_05] [RULE_06]
						n.fsm = ST_NEXT;
						n.tx_frame_n = 1'b0;
						n.div = HALF;
					end else begin
						n.fail = 1'b0;
						n.want = 1'b1;
						n.fsm = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (c.beat_v) begin
					progress = 1'b1;
					if (c.beat.fail) begin
						n.fail = 1'b1; // [RULE_06]
						n.beat_v = 1'b0;
						n.fsm = ST_NEXT;
						n.tx_frame_n = 1'b0;
						n.div = HALF;
					end else if (!c.cmd.is_read) begin
						n.beat_v = 1'b0; // [RULE_08]
						n.want = 1'b0;
						n.fsm = ST_ACK;
						n.tx_frame_n = 1'b0;
						n.div = ACK_LEN;
					end else begin
						n.fsm = ST_NEXT; // [RULE_07] [RULE_10]
						n.tx_frame_n = 1'b0;
						n.div = HALF;
					end
				end
			end
			ST_ACK: begin
				if (c.div == 16'h0) begin
					n.tx_frame_n = 1'b1;
					n.fsm = ST_IDLE;
				end
			end
			ST_NEXT: begin
				n.tx_clk = 1'b0;
				if (c.div == 16'h0 && f_frame_n) begin // [RULE_17] [RULE_13]
					if (c.idx < 2'(link_pkg::CMD_BYTES)) begin
						n.tsh = (c.idx == 2'h0) ? c.cmd.cmd0 : c.cmd.cmd1; // [RULE_06] [RULE_07]
						n.idx = c.idx + 2'h1;
						n.fsm = ST_SEND;
					end else if (c.fail || c.last_sent) begin
						n.fsm = ST_END;
						n.div = HALF;
					end else if (c.beat_v) begin
						n.beat_v = 1'b0;
						if (c.beat.fail) begin
							n.want = 1'b0;
							n.fsm = ST_END;
							n.div = HALF;
						end else begin
							n.tsh = c.beat.data;
							n.last_sent = c.beat.last;
							n.fsm = ST_SEND;
						end
					end
					if (n.fsm == ST_SEND) begin
						progress = 1'b1;
						n.tx_data = n.tsh[7]; // [RULE_26]
						n.tbit = 3'h0;
						n.phase = 1'b0;
						n.div = HALF;
					end
				end
			end
			ST_SEND: begin
				if (c.div == 16'h0) begin
					n.div = HALF;
					if (!c.phase) begin
						n.tx_clk = 1'b1;
						n.phase = 1'b1;
					end else begin
						n.tx_clk = 1'b0;
						n.phase = 1'b0;
						if (c.tbit == 3'(link_pkg::BYTE_BITS - 1)) begin
							n.fsm = ST_NEXT; // [RULE_15] [RULE_17]
							n.div = 16'h0;
						end else begin
							n.tbit = c.tbit + 3'h1;
							n.tsh = {c.tsh[6:0], 1'b0};
							n.tx_data = c.tsh[6]; // [RULE_26]
						end
					end
				end
			end
			ST_END: begin
				n.tx_clk = 1'b0;
				if (c.div == 16'h0) begin
					n.tx_frame_n = 1'b1; // [RULE_02] [RULE_12]
					n.tx_data = 1'b0;
					n.fsm = ST_IDLE;
				end
			end
			default: begin
				n.fsm = ST_IDLE;
				n.tx_frame_n = 1'b1;
			end
		endcase
		// watchdog on stalled activity
		if (c.fsm == ST_IDLE || progress) begin
			n.wd = 32'h0;
		end else if (c.wd != 32'hFFFFFFFF) begin
			n.wd = c.wd + 32'h1;
		end
		// shared reset line drive with stretch
		if (c.io_oe) begin
			if (c.io_cnt == 32'h0) begin
				n.io_oe = 1'b0;
			end else begin
				n.io_cnt = c.io_cnt - 32'h1;
			end
		end else if (io_rst_req || c.wd >= WDOG_LEN) begin // [RULE_20] [RULE_24]
			n.io_oe = 1'b1;
			n.io_cnt = IO_LEN - 32'h1; // [RULE_21]
		end
		n.link_rst = n.io_oe || !n.filt[3];
		// link logic back to its initial state, keeping reset line logic
		if (c.link_rst) begin // [RULE_22] [RULE_23]
			n = {INIT[$bits(state_s)-1:0]};
			n.sync1 = {io_rst_i, rx_data, rx_clk, rx_frame_n};
			n.sync2 = c.sync1;
			n.sync3 = c.sync2;
			for (int i = 0; i < 4; i++) begin
				n.filt[i] = (c.sync2[i] == c.sync3[i]) ? c.sync3[i] : c.filt[i];
			end
			n.io_oe = c.io_oe && (c.io_cnt != 32'h0);
			n.io_cnt = (c.io_cnt != 32'h0) ? c.io_cnt - 32'h1 : 32'h0;
			n.link_rst = n.io_oe || !n.filt[3];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			c <= INIT;
		end else begin
			c <= n;
		end
	end

	// outputs straight from the state register, except io_rst_o, which is tied low
	assign tx_frame_n = c.tx_frame_n; // [RULE_11]
	assign tx_clk = c.tx_clk;
	assign tx_data = c.tx_data;
	assign io_rst_o = 1'b0;
	assign io_rst_oe = c.io_oe;
	assign rx_valid = c.out_v;
	assign rx_beat = c.out_b;
	assign cmd_valid = c.cmd_v;
	assign cmd = c.cmd;
	assign rsp_ready = c.rsp_rdy;
	assign link_reset = c.link_rst;
endmodule : cmd_link_unit

/* include/link_pkg.sv */
// constants and carriers of the framed serial command link
package link_pkg;
	// system clock
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_NS = 8;
	// link clock made by this end
	localparam int LINK_MAX_HZ = 10_000_000;
	localparam int LINK_HZ = 100_000;
	localparam int TX_HALF_CYC = (CLK_HZ + 2 * LINK_HZ - 1) / (2 * LINK_HZ);
	// good write ack: frame low without clocks
	localparam int ACK_NS = 800;
	localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS;
	// shared reset line stretch
	localparam int IORST_MS = 200;
	localparam int IORST_CYC = IORST_MS * (CLK_HZ / 1000);
	// watchdog
	localparam int WDOG_S = 30;
	localparam logic [31:0] WDOG_CYC = 32'(64'(WDOG_S) * 64'(CLK_HZ));
	// stream layout
	localparam int CMD_BYTES = 2;
	localparam int MIN_BYTES = 4;
	localparam int HOLD_AT = 4;
	localparam int BYTE_BITS = 8;
	// first command byte fields
	localparam int CMD0_DIR_BIT = 6;
	localparam int CMD0_LONG_BIT = 5;
	localparam int CMD0_SEL_HI = 4;
	localparam int CMD0_SEL_LO = 2;
	localparam int CMD0_RSV_HI = 1;
	localparam int CMD0_RSV_LO = 0;
	localparam logic [2:0] ITEM_MAX = 3'h4;
	// received byte towards the user
	typedef struct packed {
		logic [7:0] data;
		logic first;
	} rx_beat_s;
	// decoded command, given at frame end
	typedef struct packed {
		logic [7:0] cmd0;
		logic [7:0] cmd1;
		logic is_read;
		logic is_long;
		logic bad;
		logic [15:0] bytes;
	} cmd_info_s;
	// response beat from the user
	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic fail;
	} rsp_beat_s;
endpackage : link_pkg

/* test/cmd_link_unit_asserts.sv */
// port assertions for the acquisition-unit link end
`timescale 1ns/100ps
module cmd_link_checks #(
	parameter int IORST_LEN = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link pins
	input wire logic rx_frame_n,
	input wire logic tx_frame_n,
	input wire logic tx_clk,
	input wire logic tx_data,
	// shared reset line
	input wire logic io_rst_i,
	input wire logic io_rst_o,
	input wire logic io_rst_oe,
	input wire logic io_rst_req,
	// user side
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire link_pkg::rx_beat_s rx_beat,
	input wire logic cmd_valid,
	input wire logic link_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [31:0] oe_cnt_reg;
	// how long our reset drive has stood
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			oe_cnt_reg <= 32'h0;
		else
			oe_cnt_reg <= io_rst_oe ? oe_cnt_reg + 32'h1 : 32'h0;
	end
	a_clk_in_frame: assert property (tx_clk |-> !tx_frame_n) else $error("clock outside frame");
	a_reply_after_frame: assert property ((!rx_frame_n)[*5] |-> !tx_clk) else $error("reply in frame");
	a_cmd_at_end: assert property (cmd_valid |-> $past(rx_frame_n, 3) ##1 !cmd_valid) else $error("cmd");
	a_data_on_fall: assert property ($rose(tx_clk) |-> ##1 (tx_clk && $stable(tx_data))[*4])
		else $error("data moved while clock high");
	a_hold_when_full: assert property ((!rx_frame_n)[*5] ##0 rx_valid |-> !tx_frame_n) else $error("no hold");
	a_beat_kept: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_beat)) else $error("beat lost");
	a_pull_low: assert property (io_rst_oe |-> !io_rst_o) else $error("reset line driven high");
	a_req_pulls: assert property ($rose(io_rst_req) |-> ##[1:3] io_rst_oe) else $error("no reset drive");
	a_reset_length: assert property ($fell(io_rst_oe) |-> oe_cnt_reg >= 32'(IORST_LEN)) else $error("short");
	a_line_resets: assert property ((!io_rst_i)[*4] |-> ##[0:3] link_reset) else $error("line ignored");
endmodule : cmd_link_checks
bind cmd_link_unit cmd_link_checks #(.IORST_LEN(IORST_LEN)) checks (.clk(clk), .arst_n(arst_n),
	.rx_frame_n(rx_frame_n), .tx_frame_n(tx_frame_n), .tx_clk(tx_clk), .tx_data(tx_data), .io_rst_i(io_rst_i),
	.io_rst_o(io_rst_o), .io_rst_oe(io_rst_oe), .io_rst_req(io_rst_req), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.rx_beat(rx_beat), .cmd_valid(cmd_valid), .link_reset(link_reset));

/* test/ctrl_model.sv */
// controller end of the link: sends frames, collects replies
`timescale 1ns/100ps
module ctrl_model (
	// towards the unit
	output logic frame_n,
	output logic lclk,
	output logic ldata,
	// from the unit
	input wire logic ret_frame_n,
	input wire logic ret_clk,
	input wire logic ret_data
);
	logic [7:0] got_q[$];
	logic [7:0] sh;
	int nbit = 0;
	initial begin
		frame_n = 1'b1;
		lclk = 1'b0;
		ldata = 1'b0;
	end
	task automatic send(input logic [7:0] b);
		while (ret_frame_n !== 1'b1) @(posedge ret_frame_n);
		for (int i = 7; i >= 0; i--) begin
			ldata = b[i];
			#62;
			lclk = 1'b1;
			#63;
			lclk = 1'b0;
		end
	endtask : send
	task automatic frame(input logic [7:0] b[$]);
		#3;
		frame_n = 1'b0;
		#125;
		foreach (b[i]) send(b[i]);
		#125;
		frame_n = 1'b1;
		ldata = ~ldata;
	endtask : frame
	task automatic stall_frame(input int t);
		frame_n = 1'b0;
		#t;
		frame_n = 1'b1;
	endtask : stall_frame
	always @(posedge ret_clk) begin
		if (ret_frame_n === 1'b0) begin
			sh = {sh[6:0], ret_data};
			nbit = nbit + 1;
			if (nbit == 8) begin
				got_q.push_back(sh);
				nbit = 0;
			end
		end
	end
endmodule : ctrl_model

/* test/framed_serial_command_link_bench.sv */
// bench for the acquisition-unit end of the link
`timescale 1ns/100ps
module framed_serial_command_link_bench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic rx_frame_n, rx_clk, rx_data, tx_frame_n, tx_clk, tx_data;
	logic io_rst_i, io_rst_o, io_rst_oe, link_reset, cmd_valid, rx_valid, rsp_ready;
	logic io_rst_req = 1'b0;
	logic ext_rst_n = 1'b1;
	logic rx_ready = 1'b1;
	logic long_path_ready = 1'b1;
	logic rsp_valid = 1'b0;
	link_pkg::rx_beat_s rx_beat;
	link_pkg::cmd_info_s cmd;
	link_pkg::rsp_beat_s rsp = '0;
	logic [7:0] seen_q[$];
	int n_errors = 0;
	int cmp_count = 0;
	int n_cmd = 0;
	always #4 clk = ~clk;
	assign io_rst_i = io_rst_oe ? io_rst_o : ext_rst_n;
	cmd_link_unit #(.TX_HALF(4), .IORST_LEN(50), .WDOG_LEN(32'h190), .ITEM_LIMIT(3'h4)) dut (.clk(clk),
		.arst_n(arst_n), .rx_frame_n(rx_frame_n), .rx_clk(rx_clk), .rx_data(rx_data), .tx_frame_n(tx_frame_n),
		.tx_clk(tx_clk), .tx_data(tx_data), .io_rst_i(io_rst_i), .io_rst_o(io_rst_o), .io_rst_oe(io_rst_oe),
		.io_rst_req(io_rst_req), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
		.long_path_ready(long_path_ready), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp(rsp), .link_reset(link_reset));
	ctrl_model ctrl (.frame_n(rx_frame_n), .lclk(rx_clk), .ldata(rx_data), .ret_frame_n(tx_frame_n),
		.ret_clk(tx_clk), .ret_data(tx_data));
	task automatic check(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : check
	always @(posedge clk) begin
		if (cmd_valid === 1'b1)
			n_cmd++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
			check(rx_beat.first === (seen_q.size() == 0), "first flag");
			seen_q.push_back(rx_beat.data);
		end
	end
	task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$], input string m);
		check(g.size() == e.size(), m);
		foreach (e[i])
			if (i < g.size()) check(g[i] === e[i], m);
	endtask : cmp_q
	task automatic xfer(input logic [7:0] b[$]);
		seen_q.delete();
		ctrl.got_q.delete();
		ctrl.frame(b);
	endtask : xfer
	task automatic beat(input logic [7:0] d, input logic last, input logic fail);
		int k;
		k = 0;
		@(posedge clk);
		rsp <= '{data: d, last: last, fail: fail};
		rsp_valid <= 1'b1;
		@(posedge clk);
		while (rsp_ready !== 1'b1 && k < 1000) begin
			@(posedge clk);
			k++;
		end
		rsp_valid <= 1'b0;
		check(k < 1000, "beat not taken");
	endtask : beat
	task automatic wait_reply(output int lo);
		int k;
		k = 0;
		lo = 0;
		while (tx_frame_n !== 1'b0 && k < 2000) begin
			@(posedge clk);
			k++;
		end
		while (tx_frame_n === 1'b0 && k < 4000) begin
			@(posedge clk);
			k++;
			lo++;
		end
		check(k < 2000, "no reply frame");
	endtask : wait_reply
	task automatic t_write;
		int lo;
		int nc;
		nc = n_cmd;
		xfer('{8'h04, 8'h03, 8'h12, 8'h34});
		beat(8'h00, 1'b1, 1'b0);
		wait_reply(lo);
		cmp_q(seen_q, '{8'h04, 8'h03, 8'h12, 8'h34}, "write bytes");
		check(n_cmd == nc + 1 && cmd.bad === 1'b0 && cmd.bytes === 16'h0004, "write cmd");
		check(lo == link_pkg::ACK_CYC + 1 && ctrl.got_q.size() == 0, "good ack");
		$display("test write done");
	endtask : t_write
	task automatic bad_one(input logic [7:0] b[$]);
		int lo;
		xfer(b);
		wait_reply(lo);
		check(cmd.bad === 1'b1, "bad not flagged");
		cmp_q(ctrl.got_q, '{b[0], b[1]}, "error echo");
	endtask : bad_one
	task automatic t_bad;
		int lo;
		bad_one('{8'h05, 8'h11, 8'h00, 8'h00});
		bad_one('{8'h14, 8'h22, 8'h00, 8'h00});
		bad_one('{8'h04, 8'h33});
		xfer('{8'h08, 8'hA5, 8'h01, 8'h02});
		beat(8'h00, 1'b1, 1'b1);
		wait_reply(lo);
		cmp_q(ctrl.got_q, '{8'h08, 8'hA5}, "fail echo");
		$display("test refusals done");
	endtask : t_bad
	task automatic t_read;
		int lo;
		xfer('{8'h48, 8'h05, 8'h00, 8'h00});
		repeat (8) @(posedge clk);
		check(cmd.is_read === 1'b1, "read decode");
		beat(8'hAA, 1'b0, 1'b0);
		beat(8'hBB, 1'b1, 1'b0);
		wait_reply(lo);
		cmp_q(ctrl.got_q, '{8'h48, 8'h05, 8'hAA, 8'hBB}, "read reply");
		$display("test read done");
	endtask : t_read
	task automatic t_long;
		int lo;
		rx_ready <= 1'b0;
		long_path_ready <= 1'b0;
		fork
			xfer('{8'h24, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15});
			begin
				repeat (300) @(posedge clk);
				check(tx_frame_n === 1'b0 && seen_q.size() == 0, "hold while full");
				rx_ready <= 1'b1;
				repeat (480) @(posedge clk);
				check(tx_frame_n === 1'b0 && seen_q.size() == 4, "long path hold");
				long_path_ready <= 1'b1;
			end
		join
		beat(8'h00, 1'b1, 1'b0);
		wait_reply(lo);
		cmp_q(seen_q, '{8'h24, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15}, "long bytes");
		check(cmd.is_long === 1'b1 && cmd.bytes === 16'h0008, "long decode");
		$display("test long write done");
	endtask : t_long
	task automatic t_reset;
		int n;
		n = 0;
		io_rst_req <= 1'b1;
		@(posedge clk);
		io_rst_req <= 1'b0;
		@(posedge clk);
		while (io_rst_oe === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(n == 49 || n == 50 || n == 51, "drive length");
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		check(link_reset === 1'b1 && io_rst_oe === 1'b0, "line reset");
		ext_rst_n <= 1'b1;
		n = 0;
		fork
			begin
				// let the line reset clear first, or the frame fall is lost
				repeat (8) @(posedge clk);
				ctrl.stall_frame(3600);
			end
			while (io_rst_oe !== 1'b1 && n < 600) begin
				@(posedge clk);
				n++;
			end
		join
		check(n >= 400 && n < 460, "watchdog");
		repeat (100) @(posedge clk);
		$display("test io reset done");
	endtask : t_reset
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	initial begin
		#400000;
		n_errors++;
		$display("unexpected at %0t: run hung", $time);
		stop_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_bad();
		t_read();
		t_long();
		t_reset();
		t_write();
		stop_test();
	end
endmodule : framed_serial_command_link_bench
